// ---- timer_channel_config_params.svh ----
// register offsets, field positions and reset values of the timer channel configuration
// assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register
`ifndef TIMER_CHANNEL_CONFIG_PARAMS_SVH
`define TIMER_CHANNEL_CONFIG_PARAMS_SVH

`define TCC_OFS_TIMER_CONTROL 8'h00
`define TCC_OFS_MODE_SELECT 8'h04
`define TCC_OFS_IO_CONTROL 8'h08
`define TCC_OFS_SYNC_CONFIG 8'h0c
`define TCC_OFS_STATUS 8'h10

`define TCC_CLEAR_HI 7
`define TCC_CLEAR_LO 5
`define TCC_EDGE_HI 4
`define TCC_EDGE_LO 3
`define TCC_PRESCALE_HI 2
`define TCC_PRESCALE_LO 0
`define TCC_SYNC_BIT 0

`define TCC_RESET_TIMER_CONTROL 8'h00
`define TCC_RESET_MODE_SELECT 8'hc0
`define TCC_MODE_FIXED_HI 4'hc
`define TCC_RESET_IO_CONTROL 8'h00

`define TCC_CLR_NONE 3'h0
`define TCC_CLR_REG_A 3'h1
`define TCC_CLR_REG_B 3'h2
`define TCC_CLR_SYNC 3'h3

`define TCC_PSC_DIV1 3'h0
`define TCC_PSC_DIV4 3'h1
`define TCC_PSC_DIV16 3'h2
`define TCC_PSC_DIV64 3'h3
`define TCC_PSC_EXT_A 3'h4
`define TCC_PSC_EXT_B 3'h5
`define TCC_PSC_EXT_C 3'h6
`define TCC_PSC_DIV1024 3'h7

`define TCC_MODE_NORMAL 4'h0
`define TCC_MODE_PWM1 4'h2
`define TCC_MODE_PWM2 4'h3
`define TCC_MODE_PHASE1 4'h4
`define TCC_MODE_PHASE4 4'h7

`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

`endif

// ---- timer_channel_config_pkg.sv ----
// types shared by the timer channel configuration block
// assumes the constants header is included where offsets are needed
package timer_channel_config_pkg;
	typedef logic [7:0] reg8_t;
	typedef enum logic [1:0] {src_internal, src_external, src_phase} count_src_e;
endpackage

// ---- timer_channel_config.sv ----
// timer channel configuration: clock source, edge, clear source, mode and pin control
// assumes an AXI4-Lite master on aclk and a counter datapath that reports compare matches
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "timer_channel_config_params.svh"

module timer_channel_config
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clk_in_a,
	input wire logic ext_clk_in_b,
	input wire logic ext_clk_in_c,
	input wire logic cap_cmp_pin_a_in,
	output logic cap_cmp_pin_a_out,
	output logic cap_cmp_pin_a_oe,
	input wire logic cap_cmp_pin_b_in,
	output logic cap_cmp_pin_b_out,
	output logic cap_cmp_pin_b_oe,
	input wire logic compare_match_a,
	input wire logic compare_match_b,
	input wire logic sync_clear_in,
	output logic count_tick,
	output logic counter_clear,
	output logic sync_clear_out,
	output logic capture_a,
	output logic capture_b
);

	timer_channel_config_pkg::reg8_t channel_timer_control;
	logic [3:0] channel_mode_sel;
	timer_channel_config_pkg::reg8_t channel_io_control;
	logic sync_enable;

	logic [31:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic do_write;
	logic [7:0] wr_ofs;
	logic wr_ok;
	logic [7:0] rd_ofs;
	logic [7:0] rd_value;
	logic rd_ok;

	logic [2:0] clear_source_sel;
	logic [1:0] count_edge_sel;
	logic [2:0] prescale_sel;
	logic [3:0] io_ctrl_a;
	logic [3:0] io_ctrl_b;

	// synchroniser for ext clocks a/b/c and capture pins a/b
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic [4:0] pin_prev;
	logic [4:0] pin_rise;
	logic [4:0] pin_fall;

	logic [9:0] pre_cnt;
	logic sel_level;
	logic sel_level_d;
	logic sel_rise;
	logic sel_fall;
	logic next_tick;
	timer_channel_config_pkg::count_src_e count_src;

	logic [1:0] pin_level;
	logic [1:0] pin_oe;
	logic [1:0] next_capture;
	logic [1:0] cmp_event;
	logic [1:0] io_write;
	logic [3:0] io_code [0:1];
	logic [1:0] cmp_in;
	logic local_clear;
	logic next_clear;

	assign clear_source_sel = {1'b0, channel_timer_control[6:5]};
	assign count_edge_sel = channel_timer_control[`TCC_EDGE_HI:`TCC_EDGE_LO];
	assign prescale_sel = channel_timer_control[`TCC_PRESCALE_HI:`TCC_PRESCALE_LO];
	assign io_ctrl_a = channel_io_control[3:0];
	assign io_ctrl_b = channel_io_control[7:4];
	assign io_code[0] = io_ctrl_a;
	assign io_code[1] = io_ctrl_b;
	assign cmp_in = {compare_match_b, compare_match_a};

	// write side: address and data taken in either order
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_ofs = aw_addr[7:0];
	assign wr_ok = (aw_addr[31:8] == 24'h000000) && (wr_ofs[1:0] == 2'h0) &&
		(wr_ofs <= `TCC_OFS_STATUS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 32'h00000000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (do_write)
			w_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		else
		begin
			s_axi_awready <= !(aw_held || (s_axi_awvalid && s_axi_awready)) || do_write;
			s_axi_wready <= !(w_held || (s_axi_wvalid && s_axi_wready)) || do_write;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TCC_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// configuration registers, byte lane 0 only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			channel_timer_control <= `TCC_RESET_TIMER_CONTROL;
			channel_mode_sel <= 4'(`TCC_RESET_MODE_SELECT);
			channel_io_control <= `TCC_RESET_IO_CONTROL;
			sync_enable <= 1'b0;
		end
		else if (do_write && wr_ok && w_strb[0])
		begin
			case (wr_ofs)
				`TCC_OFS_TIMER_CONTROL: channel_timer_control <= {1'b0, w_data[6:0]};
				`TCC_OFS_MODE_SELECT: channel_mode_sel <= w_data[3:0];
				`TCC_OFS_IO_CONTROL: channel_io_control <= w_data[7:0];
				`TCC_OFS_SYNC_CONFIG: sync_enable <= w_data[`TCC_SYNC_BIT];
				default: ;
			endcase
		end
	end

	assign io_write[0] = do_write && wr_ok && w_strb[0] && (wr_ofs == `TCC_OFS_IO_CONTROL);
	assign io_write[1] = io_write[0];

	// read side
	assign rd_ofs = s_axi_araddr[7:0];
	assign rd_ok = (s_axi_araddr[31:8] == 24'h000000) && (rd_ofs[1:0] == 2'h0) &&
		(rd_ofs <= `TCC_OFS_STATUS);

	always_comb
	begin
		rd_value = 8'h00;
		case (rd_ofs)
			`TCC_OFS_TIMER_CONTROL: rd_value = {1'b0, channel_timer_control[6:0]};
			`TCC_OFS_MODE_SELECT: rd_value = {`TCC_MODE_FIXED_HI, channel_mode_sel};
			`TCC_OFS_IO_CONTROL: rd_value = channel_io_control;
			`TCC_OFS_SYNC_CONFIG: rd_value = {7'h00, sync_enable};
			`TCC_OFS_STATUS: rd_value = {2'h0, pin_level, pin_oe,
				(count_src == timer_channel_config_pkg::src_external),
				(count_src == timer_channel_config_pkg::src_phase)};
			default: rd_value = 8'h00;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `TCC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_ok ? {24'h000000, rd_value} : 32'h00000000;
			s_axi_rresp <= rd_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// pin synchronisers and edge detection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta <= 5'h00;
			pin_sync <= 5'h00;
			pin_prev <= 5'h00;
		end
		else
		begin
			pin_meta <= {cap_cmp_pin_b_in, cap_cmp_pin_a_in, ext_clk_in_c, ext_clk_in_b,
				ext_clk_in_a};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign pin_rise = pin_sync & ~pin_prev;
	assign pin_fall = ~pin_sync & pin_prev;

	// count source selection
	always_comb
	begin
		if (channel_mode_sel[3:2] == 2'h1)
			count_src = timer_channel_config_pkg::src_phase;
		else if (prescale_sel[2] && (prescale_sel != `TCC_PSC_DIV1024))
			count_src = timer_channel_config_pkg::src_external;
		else
			count_src = timer_channel_config_pkg::src_internal;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre_cnt <= 10'h000;
		else
			pre_cnt <= pre_cnt + 10'h001;
	end

	always_comb
	begin
		sel_level = 1'b0;
		case (prescale_sel)
			`TCC_PSC_DIV4: sel_level = pre_cnt[1];
			`TCC_PSC_DIV16: sel_level = pre_cnt[3];
			`TCC_PSC_DIV64: sel_level = pre_cnt[5];
			`TCC_PSC_DIV1024: sel_level = pre_cnt[9];
			`TCC_PSC_EXT_A: sel_level = pin_sync[0];
			`TCC_PSC_EXT_B: sel_level = pin_sync[1];
			`TCC_PSC_EXT_C: sel_level = pin_sync[2];
			default: sel_level = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sel_level_d <= 1'b0;
		else
			sel_level_d <= sel_level;
	end

	assign sel_rise = sel_level & ~sel_level_d;
	assign sel_fall = ~sel_level & sel_level_d;

	always_comb
	begin
		next_tick = 1'b0;
		if (count_src == timer_channel_config_pkg::src_phase)
			next_tick = 1'b0;
		else if (prescale_sel == `TCC_PSC_DIV1)
			next_tick = 1'b1;
		else if (count_edge_sel[1])
			next_tick = sel_rise | sel_fall;
		else if (count_edge_sel[0])
			next_tick = sel_fall;
		else
			next_tick = sel_rise;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_tick <= 1'b0;
		else
			count_tick <= next_tick;
	end

	// per general register: output compare or input capture
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			cmp_event[i] = cmp_in[i] && !io_code[i][3];
			if (!io_code[i][3])
				next_capture[i] = 1'b0;
			else if (io_code[i][1])
				next_capture[i] = pin_rise[3 + i] | pin_fall[3 + i];
			else if (io_code[i][0])
				next_capture[i] = pin_fall[3 + i];
			else
				next_capture[i] = pin_rise[3 + i];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_level <= 2'h0;
			pin_oe <= 2'h0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				pin_oe[i] <= !io_code[i][3] && (io_code[i][1:0] != 2'h0);
				if (io_write[i] && !w_data[4 * i + 3])
					pin_level[i] <= w_data[4 * i + 2];
				else if (cmp_event[i])
				begin
					case (io_code[i][1:0])
						2'h1: pin_level[i] <= 1'b0;
						2'h2: pin_level[i] <= 1'b1;
						2'h3: pin_level[i] <= !pin_level[i];
						default: pin_level[i] <= pin_level[i];
					endcase
				end
			end
		end
	end

	assign cap_cmp_pin_a_out = pin_level[0];
	assign cap_cmp_pin_b_out = pin_level[1];
	assign cap_cmp_pin_a_oe = pin_oe[0];
	assign cap_cmp_pin_b_oe = pin_oe[1];

	// counter clear source
	always_comb
	begin
		local_clear = 1'b0;
		next_clear = 1'b0;
		case (clear_source_sel)
			`TCC_CLR_NONE: next_clear = 1'b0;
			`TCC_CLR_REG_A:
			begin
				local_clear = cmp_event[0] | next_capture[0];
				next_clear = local_clear;
			end
			`TCC_CLR_REG_B:
			begin
				local_clear = cmp_event[1] | next_capture[1];
				next_clear = local_clear;
			end
			`TCC_CLR_SYNC: next_clear = sync_clear_in && sync_enable;
			default: next_clear = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			counter_clear <= 1'b0;
			sync_clear_out <= 1'b0;
			capture_a <= 1'b0;
			capture_b <= 1'b0;
		end
		else
		begin
			counter_clear <= next_clear;
			sync_clear_out <= local_clear && sync_enable;
			capture_a <= next_capture[0];
			capture_b <= next_capture[1];
		end
	end

endmodule

// ---- timer_channel_config_chk.sv ----
// port checker for the timer channel configuration block
// assumes it is bound into timer_channel_config, single clock aclk
`timescale 1ns/1ps
module timer_channel_config_chk
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_arready,
	input wire logic counter_clear,
	input wire logic sync_clear_out,
	input wire logic compare_match_a,
	input wire logic compare_match_b,
	input wire logic sync_clear_in,
	input wire logic capture_a,
	input wire logic capture_b,
	input wire logic cap_cmp_pin_a_in,
	input wire logic cap_cmp_pin_a_oe,
	input wire logic cap_cmp_pin_b_in,
	input wire logic cap_cmp_pin_b_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_bresp_held: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed early");
	chk_rdata_held: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed early");
	chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted during read response");
	chk_reset_idle: assert property (
		disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !counter_clear
		&& !cap_cmp_pin_a_oe && !cap_cmp_pin_b_oe && !capture_a && !capture_b)
		else $error("outputs not idle after reset");
	chk_clear_cause: assert property (
		counter_clear |-> $past(compare_match_a) || $past(compare_match_b)
		|| $past(sync_clear_in) || capture_a || capture_b || $past(capture_a) || $past(capture_b))
		else $error("counter clear without a cause");
	chk_sync_out: assert property (sync_clear_out |-> counter_clear)
		else $error("sync clear out without local clear");
	chk_cap_b_idle: assert property (capture_b |-> !cap_cmp_pin_b_oe)
		else $error("capture b while pin b driven");
	chk_cap_a_idle: assert property (capture_a |-> !cap_cmp_pin_a_oe)
		else $error("capture a while pin a driven");
	chk_cap_b_edge: assert property (
		capture_b |-> $past(cap_cmp_pin_b_in, 3) != $past(cap_cmp_pin_b_in, 4))
		else $error("capture b without pin edge");
	chk_cap_a_edge: assert property (
		capture_a |-> $past(cap_cmp_pin_a_in, 3) != $past(cap_cmp_pin_a_in, 4))
		else $error("capture a without pin edge");
endmodule

bind timer_channel_config timer_channel_config_chk timer_channel_config_chk_inst
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_arready(s_axi_arready), .counter_clear(counter_clear),
	.sync_clear_out(sync_clear_out), .compare_match_a(compare_match_a),
	.compare_match_b(compare_match_b), .sync_clear_in(sync_clear_in), .capture_a(capture_a),
	.capture_b(capture_b), .cap_cmp_pin_a_in(cap_cmp_pin_a_in),
	.cap_cmp_pin_a_oe(cap_cmp_pin_a_oe), .cap_cmp_pin_b_in(cap_cmp_pin_b_in),
	.cap_cmp_pin_b_oe(cap_cmp_pin_b_oe)
);

// ---- pin_model.sv ----
// far-side pins: external count clocks and capture/compare pin drivers
// assumes the bench calls its tasks; design drive wins while its enable is high
`timescale 1ns/1ps
module pin_model
(
	input wire logic aclk,
	input wire logic a_out,
	input wire logic a_oe,
	input wire logic b_out,
	input wire logic b_oe,
	output logic [2:0] ext_clk,
	output logic a_in,
	output logic b_in
);
	logic [1:0] pin_lvl = 2'h0;
	initial ext_clk = 3'h0;
	assign a_in = a_oe ? a_out : pin_lvl[0];
	assign b_in = b_oe ? b_out : pin_lvl[1];
	// clock stands still between pulses
	task clk_pulses(input int k, input int n);
		repeat (n)
		begin
			@(posedge aclk);
			ext_clk[k] <= 1'b1;
			repeat (3) @(posedge aclk);
			ext_clk[k] <= 1'b0;
			repeat (3) @(posedge aclk);
		end
	endtask
	task drive_pins(input logic [1:0] v);
		@(posedge aclk);
		pin_lvl <= v;
		repeat (8) @(posedge aclk);
	endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the timer channel configuration block
// assumes the pin_model partner and the bound port checker
`timescale 1ns/1ps
`include "timer_channel_config_params.svh"
module testbench;
	logic aclk;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [2:0] ev = 3'h0;
	logic [1:0] rsp;
	wire logic awready, wready, bvalid, arready, rvalid, tick, clr, sync_out, cap_a, cap_b;
	wire logic a_in, a_out, a_oe, b_in, b_out, b_oe;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0] ext_clk;
	int fails = 0;
	int checked = 0;
	int ticks = 0, clears = 0, syncs = 0, caps_a = 0, caps_b = 0;
	timer_channel_config timer_channel_config_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_clk_in_a(ext_clk[0]), .ext_clk_in_b(ext_clk[1]),
		.ext_clk_in_c(ext_clk[2]), .cap_cmp_pin_a_in(a_in), .cap_cmp_pin_a_out(a_out),
		.cap_cmp_pin_a_oe(a_oe), .cap_cmp_pin_b_in(b_in), .cap_cmp_pin_b_out(b_out),
		.cap_cmp_pin_b_oe(b_oe), .compare_match_a(ev[0]), .compare_match_b(ev[1]),
		.sync_clear_in(ev[2]), .count_tick(tick), .counter_clear(clr),
		.sync_clear_out(sync_out), .capture_a(cap_a), .capture_b(cap_b));
	pin_model pin_model_inst (.aclk(aclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
		.b_oe(b_oe), .ext_clk(ext_clk), .a_in(a_in), .b_in(b_in));
	always @(posedge aclk)
	begin
		ticks <= ticks + int'(tick === 1'b1);
		clears <= clears + int'(clr === 1'b1);
		syncs <= syncs + int'(sync_out === 1'b1);
		caps_a <= caps_a + int'(cap_a === 1'b1);
		caps_b <= caps_b + int'(cap_b === 1'b1);
	end
	task tally_and_finish;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task check_word(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s exp %0h got %0h", n, e, g);
		end
	endtask
	task check_bit(input string n, input logic e, input logic g);
		check_word(n, {31'h0, e}, {31'h0, g});
	endtask
	task check_count(input string n, input int e, input int g);
		checked++;
		if (g < e - int'(e > 8) || g > e + int'(e > 8))
		begin
			fails++;
			$display("CHECK FAILED %s exp %0d got %0d", n, e, g);
		end
	endtask
	task timed_out;
		fails++;
		$display("CHECK FAILED timeout exp 0 got 1");
		tally_and_finish;
	endtask
	task axi_write(input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		if (i == 100)
			timed_out;
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task axi_read(input logic [7:0] a);
		int i;
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		if (i == 100)
			timed_out;
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task pulse_events(input logic [2:0] v);
		@(posedge aclk);
		ev <= v;
		@(posedge aclk);
		ev <= 3'h0;
		repeat (4) @(posedge aclk);
	endtask
	task t_reset;
		axi_read(8'h00);
		check_word("timer_control", 32'h0, rd);
		axi_read(8'h04);
		check_word("mode_select", 32'hc0, rd);
		axi_read(8'h08);
		check_word("io_control", 32'h0, rd);
		axi_read(8'h14);
		check_word("unmapped", {30'h0, `TCC_RESP_SLVERR}, {30'h0, rsp});
		axi_write(8'h14, 8'h00);
		check_word("write error", {30'h0, `TCC_RESP_SLVERR}, {30'h0, rsp});
		axi_write(8'h00, 8'hff);
		check_word("write resp", {30'h0, `TCC_RESP_OKAY}, {30'h0, rsp});
		axi_read(8'h00);
		check_word("clear top bit", 32'h7f, rd);
		axi_write(8'h04, 8'h37);
		axi_read(8'h04);
		check_word("mode fixed bits", 32'hc7, rd);
		axi_write(8'h04, 8'h00);
		$display("test reset_access done");
	endtask
	task t_tick;
		static logic [7:0] cfg [8] = '{8'h00, 8'h18, 8'h01, 8'h09, 8'h11, 8'h02, 8'h03, 8'h07};
		static int exp_n [8] = '{2048, 2048, 512, 512, 1024, 128, 32, 2};
		int t0;
		for (int k = 0; k < 9; k++)
		begin
			axi_write(8'h04, k == 8 ? 8'h04 : 8'h00);
			axi_write(8'h00, cfg[k % 8]);
			if (k == 8)
			begin
				axi_read(8'h10);
				check_word("status phase", 32'h1, rd);
			end
			repeat (8) @(posedge aclk);
			t0 = ticks;
			repeat (2048) @(posedge aclk);
			check_count("ticks", k == 8 ? 0 : exp_n[k], ticks - t0);
		end
		axi_write(8'h04, 8'h00);
		$display("test prescale done");
	endtask
	task t_ext;
		int t0;
		for (int k = 0; k < 3; k++)
		begin
			axi_write(8'h00, 8'(4 + k));
			axi_read(8'h10);
			check_word("status ext", 32'h2, rd);
			repeat (8) @(posedge aclk);
			t0 = ticks;
			pin_model_inst.clk_pulses((k + 1) % 3, 2);
			pin_model_inst.clk_pulses(k, 5);
			repeat (6) @(posedge aclk);
			check_count("ext ticks", 5, ticks - t0);
		end
		$display("test ext_clock done");
	endtask
	task t_clear;
		int c0, s0, e;
		for (int sy = 0; sy < 2; sy++)
		begin
			axi_write(8'h0c, 8'(sy));
			for (int code = 0; code < 4; code++)
			begin
				axi_write(8'h00, 8'(code << 5));
				for (int j = 0; j < 3; j++)
				begin
					c0 = clears;
					s0 = syncs;
					pulse_events(3'(1 << j));
					e = int'(code == j + 1 && (j < 2 || sy == 1));
					check_count("clear", e, clears - c0);
					check_count("sync out", e * int'(j < 2) * sy, syncs - s0);
				end
			end
		end
		axi_write(8'h00, 8'h00);
		$display("test clear_source done");
	endtask
	task t_pins;
		logic [3:0] c;
		for (int k = 0; k < 8; k++)
		begin
			c = 4'(k);
			axi_write(8'h08, {c, c});
			repeat (2) @(posedge aclk);
			check_bit("oe b", c[1:0] != 2'h0, b_oe);
			check_bit("oe a", c[1:0] != 2'h0, a_oe);
			if (c[1:0] != 2'h0)
			begin
				check_bit("initial level", c[2], b_out);
				check_bit("initial level a", c[2], a_out);
			end
			pulse_events(3'h3);
			if (c[1:0] != 2'h0)
			begin
				check_bit("match b", c[1:0] == 2'h3 ? !c[2] : c[1], b_out);
				check_bit("match a", c[1:0] == 2'h3 ? !c[2] : c[1], a_out);
			end
		end
		$display("test compare_pins done");
	endtask
	task t_capture;
		int a0, b0, c0, e;
		logic [3:0] c;
		axi_write(8'h00, 8'h20);
		for (int k = 8; k < 16; k++)
		begin
			c = 4'(k);
			axi_write(8'h08, {c, c});
			repeat (8) @(posedge aclk);
			a0 = caps_a;
			b0 = caps_b;
			c0 = clears;
			pin_model_inst.drive_pins(2'h3);
			e = int'(c[1] | !c[0]);
			check_count("rise b", e, caps_b - b0);
			check_count("rise a", e, caps_a - a0);
			pin_model_inst.drive_pins(2'h0);
			check_count("both b", 1 + int'(c[1]), caps_b - b0);
			check_count("both a", 1 + int'(c[1]), caps_a - a0);
			check_count("capture clear", 1 + int'(c[1]), clears - c0);
		end
		axi_write(8'h00, 8'h00);
		$display("test capture done");
	endtask
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_tick;
		t_ext;
		t_clear;
		t_pins;
		t_capture;
		tally_and_finish;
	end
endmodule
